// [rtl/led_sink_core.sv]
// led sink control logic: shift register, latch, blanking, cascade outs
// assumes host pins are asynchronous and slower than CLK by a wide margin
// assumes an analog output stage applies the drive level to the sinks
`timescale 1ns/1ps
// Function
// RL1: rising shift clock moves the register, serial data enters stage zero.
// RL2: host sets serial data before each rising shift clock edge.
// RL3: high strobe copies register into latches; low strobe holds them.
// RL4: current select low gives full current, high gives half.
// RL5: blank input high turns all sinks off; low enables them.
// RL6: first cascade output carries last stage, updated on rising edge.
// RL7: second cascade output carries last stage, updated on falling edge.
// RL8: eight sinks, zero to seven, each follows its own latch bit.
// RL9: blanking never changes latch contents.
// RL10: with strobe tied high, host keeps blank high while shifting.
// RL11: each stage passes content onward; last stage feeds both cascades.
module led_sink_core (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // host pins
   input wire logic SERIAL_DATA,
   input wire logic SHIFT_CLK,
   input wire logic LATCH_STROBE,
   input wire logic BLANK_N,
   input wire logic HALF_SEL,
   // sink drive
   output logic [7:0] SINK_DRIVERS,
   output logic DRIVE_LEVEL,
   // cascade
   output logic CASCADE_DATA_RISING,
   output logic CASCADE_DATA_FALLING
);
   // synchronised pins and shift clock edges
   led_sink_pkg::pins_t pins_raw;
   led_sink_pkg::pins_t pins_s;
   logic clk_prev_q;
   logic clk_prev_d;
   led_sink_pkg::edge_t edge_w;
   logic rise_seen;
   logic fall_seen;
   // pattern path
   logic serial_in;
   logic [7:0] shift_q, shift_d;
   logic [7:0] latch_q, latch_d;
   logic [7:0] sink_q, sink_d;
   logic latch_open;
   logic sinks_enabled;
   // drive level
   logic level_q;
   logic level_d;
   // cascade path
   logic last_stage_now;
   logic last_stage_next;
   logic rise_q, rise_d;
   logic fall_q, fall_d;

   assign pins_raw = '{data: SERIAL_DATA, shift_clk: SHIFT_CLK,
      strobe: LATCH_STROBE, blank_n: BLANK_N, half_sel: HALF_SEL};

   pin_sync u_sync (
      .clk(CLK),
      .reset(RESET),
      .pins_in(pins_raw),
      .pins_out(pins_s)
   );

   // edge of a synchronised level against its previous sample
   function automatic led_sink_pkg::edge_t classify_edge(
      input logic now_level,
      input logic last_level
   );
      led_sink_pkg::edge_t kind;
      kind = led_sink_pkg::EDGE_NONE;
      if (now_level && !last_level) begin
         kind = led_sink_pkg::EDGE_RISE;
      end
      if (!now_level && last_level) begin
         kind = led_sink_pkg::EDGE_FALL;
      end
      return kind;
   endfunction

   // one shift step; the top stage's old bit drops out here
   function automatic logic [7:0] shift_step(
      input logic [7:0] stages,
      input logic entry
   );
      logic [7:0] moved;
      moved = stages;
      for (int i = led_sink_pkg::STAGES - 1; i > 0; i--) begin
         moved[i] = stages[i - 1];
      end
      moved[0] = entry;
      return moved;
   endfunction

   // each sink follows only its own latch bit
   function automatic logic [7:0] gate_sinks(
      input logic enabled,
      input logic [7:0] pattern
   );
      logic [7:0] drive;
      drive = led_sink_pkg::SINK_OFF;
      if (enabled) begin
         for (int i = 0; i < led_sink_pkg::STAGES; i++) begin
            drive[i] = pattern[i];
         end
      end
      return drive;
   endfunction

   // current select pin to drive level code
   function automatic logic level_code(input logic half_request);
      logic code;
      code = led_sink_pkg::LEVEL_FULL;
      if (half_request) begin
         code = led_sink_pkg::LEVEL_HALF;
      end
      return code;
   endfunction

   // limitation: pin levels shorter than one CLK period may be missed
   // data and clock share sync delay, so setup at the pins is preserved
   assign clk_prev_d = pins_s.shift_clk;
   assign edge_w = classify_edge(pins_s.shift_clk, clk_prev_q);
   assign rise_seen = (edge_w == led_sink_pkg::EDGE_RISE);
   assign fall_seen = (edge_w == led_sink_pkg::EDGE_FALL);

   // RL1 RL11 shift on rise
   assign serial_in = pins_s.data;
   assign shift_d = rise_seen ? shift_step(shift_q, serial_in) : shift_q;

   // RL3 RL9 transparent latch
   assign latch_open = pins_s.strobe;
   assign latch_d = latch_open ? shift_d : latch_q;

   // RL5 RL8 blanking gate
   assign sinks_enabled = !pins_s.blank_n;
   assign sink_d = gate_sinks(sinks_enabled, latch_d);

   // RL4 current select
   assign level_d = level_code(pins_s.half_sel);

   // RL11 last stage source
   assign last_stage_now = shift_q[7];
   assign last_stage_next = shift_d[7];

   // RL6 rising cascade
   assign rise_d = last_stage_next;

   // RL7 falling cascade
   assign fall_d = fall_seen ? last_stage_now : fall_q;

   // shift clock history; resets to the idle low level, so no false edge
   always_ff @(posedge CLK) begin
      if (RESET) begin
         clk_prev_q <= led_sink_pkg::SYNC_RESET;
      end else begin
         clk_prev_q <= clk_prev_d;
      end
   end

   // RL1 shift register
   always_ff @(posedge CLK) begin
      if (RESET) begin
         shift_q <= led_sink_pkg::SHIFT_RESET;
      end else begin
         shift_q <= shift_d;
      end
   end

   // RL3 output latches
   always_ff @(posedge CLK) begin
      if (RESET) begin
         latch_q <= led_sink_pkg::LATCH_RESET;
      end else begin
         latch_q <= latch_d;
      end
   end

   // RL5 sink drive register
   always_ff @(posedge CLK) begin
      if (RESET) begin
         sink_q <= led_sink_pkg::SINK_OFF;
      end else begin
         sink_q <= sink_d;
      end
   end

   // RL4 drive level register
   always_ff @(posedge CLK) begin
      if (RESET) begin
         level_q <= led_sink_pkg::LEVEL_FULL;
      end else begin
         level_q <= level_d;
      end
   end

   // RL6 rising cascade register
   always_ff @(posedge CLK) begin
      if (RESET) begin
         rise_q <= led_sink_pkg::CASCADE_RESET;
      end else begin
         rise_q <= rise_d;
      end
   end

   // RL7 falling cascade register
   always_ff @(posedge CLK) begin
      if (RESET) begin
         fall_q <= led_sink_pkg::CASCADE_RESET;
      end else begin
         fall_q <= fall_d;
      end
   end

   // analog half current is applied by the output stage from this level
   assign SINK_DRIVERS = sink_q;
   assign DRIVE_LEVEL = level_q;
   assign CASCADE_DATA_RISING = rise_q;
   assign CASCADE_DATA_FALLING = fall_q;
endmodule // led_sink_core

// [rtl/led_sink_pkg.sv]
// shared types and constants for the serial latched led sink logic
// assumes a single 200 MHz system clock sampling all pins
package led_sink_pkg;
   localparam int STAGES = 8;
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] SINK_OFF = 8'h00;
   localparam logic SYNC_RESET = 1'h0;
   localparam logic BLANK_RESET = 1'h1;
   localparam logic CASCADE_RESET = 1'h0;
   // current select codes on the drive level output
   localparam logic LEVEL_FULL = 1'h0;
   localparam logic LEVEL_HALF = 1'h1;

   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10
   } edge_t;

   typedef struct packed {
      logic data;
      logic shift_clk;
      logic strobe;
      logic blank_n;
      logic half_sel;
   } pins_t;
endpackage

// [rtl/pin_sync.sv]
// two flip-flop synchroniser for the host pin group
// assumes pins are asynchronous to CLK
`timescale 1ns/1ps
module pin_sync (
   input wire logic clk,
   input wire logic reset,
   input wire led_sink_pkg::pins_t pins_in,
   output led_sink_pkg::pins_t pins_out
);
   led_sink_pkg::pins_t meta_q;
   led_sink_pkg::pins_t sync_q;
   localparam led_sink_pkg::pins_t IDLE_PINS = '{
      data: led_sink_pkg::SYNC_RESET,
      shift_clk: led_sink_pkg::SYNC_RESET,
      strobe: led_sink_pkg::SYNC_RESET,
      blank_n: led_sink_pkg::BLANK_RESET,
      half_sel: led_sink_pkg::SYNC_RESET};

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_q <= IDLE_PINS;
         sync_q <= IDLE_PINS;
      end else begin
         meta_q <= pins_in;
         sync_q <= meta_q;
      end
   end

   assign pins_out = sync_q;
endmodule // pin_sync

// [test/led_host.sv]
// host model driving the sink pins
// assumes pins change on falling clk
`timescale 1ns/1ps
module led_host (
   // clock
   input wire logic clk,
   // pins toward the sink logic
   output logic data,
   output logic sclk,
   output logic strobe,
   output logic blank_n,
   output logic half_sel
);
   initial {data, sclk, strobe, blank_n, half_sel} = 5'h02;
   task automatic step(input logic s, n, h);
      @(negedge clk) {strobe, blank_n, half_sel} = {s, n, h};
      repeat (6) @(negedge clk);
   endtask
   task automatic send(input logic [7:0] b);
      if (strobe) blank_n = 1'h1;
      for (int i = 7; i >= 0; i--) begin
         @(negedge clk) data = b[i];
         @(negedge clk) sclk = 1'h1;
         repeat (5) @(negedge clk);
         sclk = 1'h0;
         @(negedge clk) data = ~data;
      end
   endtask
   // data set one cycle ahead, clock left high
   task automatic rise(input logic d);
      @(negedge clk) data = d;
      @(negedge clk) sclk = 1'h1;
      repeat (5) @(negedge clk);
   endtask
   task automatic fall;
      sclk = 1'h0;
      repeat (5) @(negedge clk);
   endtask
endmodule // led_host

// [test/led_sink_props.sv]
// checker on the led sink core ports
// assumes pins change on falling CLK
`timescale 1ns/1ps
module led_sink_props (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // host pins
   input wire logic SHIFT_CLK,
   input wire logic LATCH_STROBE,
   input wire logic BLANK_N,
   input wire logic HALF_SEL,
   // outputs under check
   input wire logic DRIVE_LEVEL,
   input wire logic CASCADE_DATA_RISING,
   input wire logic CASCADE_DATA_FALLING,
   input wire logic [7:0] SINK_DRIVERS
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence sclk_low;
      !SHIFT_CLK [*5];
   endsequence
   sequence sclk_high;
      SHIFT_CLK [*5];
   endsequence
   a_blank_off: assert property (BLANK_N [*4] |-> !SINK_DRIVERS)
      else $error("sink on");
   a_level_half: assert property (HALF_SEL [*4] |-> DRIVE_LEVEL)
      else $error("not half");
   a_level_full: assert property (!HALF_SEL [*4] |-> !DRIVE_LEVEL)
      else $error("not full");
   a_level_cause: assert property ($rose(DRIVE_LEVEL) |->
      $past(HALF_SEL, 3) || $past(HALF_SEL, 4)) else $error("level");
   a_latch_hold: assert property ((!LATCH_STROBE && !BLANK_N) [*5]
      |-> $stable(SINK_DRIVERS)) else $error("latch moved");
   a_rise_hold: assert property (sclk_low |->
      $stable(CASCADE_DATA_RISING)) else $error("rise moved");
   a_fall_hold: assert property (sclk_high |->
      $stable(CASCADE_DATA_FALLING)) else $error("fall moved");
   a_cascade_same: assert property (sclk_low |->
      CASCADE_DATA_FALLING == CASCADE_DATA_RISING) else $error("cascade");
endmodule // led_sink_props
bind led_sink_core led_sink_props p (.CLK, .RESET, .SHIFT_CLK,
   .LATCH_STROBE, .BLANK_N, .HALF_SEL, .DRIVE_LEVEL, .CASCADE_DATA_RISING,
   .CASCADE_DATA_FALLING, .SINK_DRIVERS);

// [test/test_serial_latched_led_sink_logic.sv]
// bench for the led sink core
// assumes the host model drives all pins
`timescale 1ns/1ps
module test_serial_latched_led_sink_logic;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic data, sclk, strobe, blank_n, half_sel, level, c_rise, c_fall;
   logic [7:0] sinks;
   int num_errors = 0;
   int checked = 0;
   wire [7:0] casc = {6'h00, c_rise, c_fall};
   wire [7:0] lvl = {7'h00, level};
   always #2.5 clk = ~clk;
   led_host host (.clk(clk), .data(data), .sclk(sclk), .strobe(strobe),
      .blank_n(blank_n), .half_sel(half_sel));
   led_sink_core DUT (.CLK(clk), .RESET(reset), .SERIAL_DATA(data),
      .SHIFT_CLK(sclk), .LATCH_STROBE(strobe), .BLANK_N(blank_n),
      .HALF_SEL(half_sel), .SINK_DRIVERS(sinks), .DRIVE_LEVEL(level),
      .CASCADE_DATA_RISING(c_rise), .CASCADE_DATA_FALLING(c_fall));
   task automatic chk(input logic [7:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checked %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic t_shift;
      host.step(1'h0, 1'h0, 1'h0);
      host.send(8'hA5);
      host.step(1'h1, 1'h0, 1'h0);
      host.step(1'h0, 1'h0, 1'h0);
      chk(sinks, 8'hA5);
      chk(casc, 8'h03);
      host.send(8'h3C);
      host.step(1'h0, 1'h0, 1'h0);
      chk(sinks, 8'hA5);
      chk(casc, 8'h00);
      $display("shift test done");
   endtask
   task automatic t_blank;
      host.step(1'h1, 1'h1, 1'h0);
      host.send(8'h0F);
      host.step(1'h1, 1'h0, 1'h0);
      chk(sinks, 8'h0F);
      host.step(1'h0, 1'h1, 1'h1);
      chk(sinks, 8'h00);
      chk(lvl, 8'h01);
      host.step(1'h0, 1'h0, 1'h0);
      chk(sinks, 8'h0F);
      chk(lvl, 8'h00);
      $display("blank test done");
   endtask
   task automatic t_cascade;
      // from 0F three zeros keep stage 7 low, the fourth lifts it
      repeat (3) begin
         host.rise(1'h0);
         host.fall;
      end
      host.rise(1'h0);
      chk(casc, 8'h02);
      host.fall;
      chk(casc, 8'h03);
      chk(sinks, 8'h0F);
      $display("cascade test done");
   endtask
   initial begin
      repeat (10) @(negedge clk);
      reset = 1'h0;
      t_shift;
      t_blank;
      t_cascade;
      summarize;
   end
   initial begin
      #20000;
      num_errors++;
      summarize;
   end
endmodule // test_serial_latched_led_sink_logic
